// ---- src/cspr_defs.svh ----
// constants of the core status and pointer register block
// ============================================================
`ifndef CSPR_DEFS_SVH
`define CSPR_DEFS_SVH
`define CSPR_OFS_PORT0       7'h00
`define CSPR_OFS_PORT1       7'h01
`define CSPR_OFS_STATUS      7'h03
`define CSPR_OFS_PTR0_LO     7'h04
`define CSPR_OFS_PTR0_HI     7'h05
`define CSPR_OFS_PTR1_LO     7'h06
`define CSPR_OFS_PTR1_HI     7'h07
`define CSPR_OFS_BANK        7'h08
`define CSPR_OFS_ACC         7'h09
`define CSPR_OFS_PCLATCH     7'h0a
`define CSPR_OFS_INTCTL      7'h0b
`define CSPR_ADR_STKIDX      13'h1fed
`define CSPR_ADR_TOS_LO      13'h1fee
`define CSPR_ADR_TOS_HI      13'h1fef
`define CSPR_BANK_SHIFT      7
`define CSPR_BIT_TO          4
`define CSPR_BIT_PD          3
`define CSPR_BIT_Z           2
`define CSPR_BIT_DC          1
`define CSPR_BIT_C           0
`define CSPR_BIT_GIE         7
`define CSPR_BIT_PERIPHERAL_IRQ_ENABLE        6
`define CSPR_BIT_EDG         0
`define CSPR_RST_INTCTL      8'h01
`define CSPR_STACK_DEPTH     32
`endif

// ---- src/cspr_pkg.sv ----
// types of the core status and pointer register block
package cspr_pkg;
    typedef enum logic [3:0] {
        CSPR_ALU_NONE = 4'h0,
        CSPR_ALU_ADD  = 4'h1,
        CSPR_ALU_SUB  = 4'h2,
        CSPR_ALU_LOGIC = 4'h3,
        CSPR_ALU_RRC  = 4'h4,
        CSPR_ALU_RLC  = 4'h5
    } cspr_alu_type;
    typedef struct packed {
        cspr_alu_type op;
        logic [7:0]   a;
        logic [7:0]   b;
        logic         write_acc;
    } cspr_alu_req_type;
    typedef struct packed {
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic watchdog_timeout;
    } cspr_event_type;
    typedef enum logic [2:0] {
        CSPR_WB_IDLE = 3'b001,
        CSPR_WB_ACK  = 3'b010,
        CSPR_WB_REST = 3'b100
    } cspr_wb_state_type;
endpackage

// ---- src/cspr_core_regs.sv ----
// core status, pointer, bank, accumulator and interrupt control registers
`timescale 1ns/1ns
`default_nettype none
`include "cspr_defs.svh"
module cspr_core_regs (
    input  wire logic                      CLK,
    input  wire logic                      SYS_RST,
    input  wire logic                      POR_BOR,
    input  wire logic [31:0]               WB_ADR_I,
    input  wire logic [31:0]               WB_DAT_I,
    input  wire logic [3:0]                WB_SEL_I,
    input  wire logic                      WB_WE_I,
    input  wire logic                      WB_CYC_I,
    input  wire logic                      WB_STB_I,
    output var  logic [31:0]               WB_DAT_O,
    output var  logic                      WB_ACK_O,
    input  wire cspr_pkg::cspr_alu_req_type ALU_REQ,
    input  wire cspr_pkg::cspr_event_type  EVENTS,
    input  wire logic                      RST_TIMEOUT_VAL,
    input  wire logic                      RST_POWERDOWN_VAL,
    input  wire logic                      IRQ_COND,
    input  wire logic                      IRQ_FLAG_CLEAR,
    output var  logic                      IRQ_FLAG,
    output var  logic [15:0]               POINTER_ZERO,
    output var  logic [15:0]               POINTER_ONE,
    output var  logic [5:0]                BANK_SELECT,
    output var  logic [7:0]                ACCUMULATOR,
    output var  logic [6:0]                PC_LATCH,
    output var  logic                      GLOBAL_IRQ_ENABLE,
    output var  logic                      PERIPH_IRQ_ENABLE,
    output var  logic                      EXT_IRQ_EDGE_SELECT,
    output var  logic [4:0]                STACK_INDEX,
    output var  logic [15:0]               STACK_TOP,
    output var  logic [7:0]                STATUS_FLAGS,
    output var  logic                      INDIRECT_REQ,
    output var  logic                      INDIRECT_WE,
    output var  logic [15:0]               INDIRECT_ADDR,
    output var  logic [7:0]                INDIRECT_WDATA,
    input  wire logic [7:0]                INDIRECT_RDATA,
    input  wire logic                      INDIRECT_DONE
);
    import cspr_pkg::*;

    // ============================================================
    // register state
    logic [15:0]       pointer_zero;
    logic [15:0]       pointer_one;
    logic [5:0]        bank_selector;
    logic [7:0]        working_accumulator;
    logic [6:0]        pc_upper_latch;
    logic [7:0]        interrupt_control;
    logic [4:0]        return_stack_index;
    logic [15:0]       stack_mem [0:`CSPR_STACK_DEPTH-1];
    logic              timeout_flag;
    logic              powerdown_flag;
    logic              zero_flag;
    logic              digit_carry_flag;
    logic              carry_flag;
    logic              irq_flag;
    cspr_wb_state_type state;

    // ============================================================
    // decode
    function automatic logic [6:0] bank_ofs(input logic [31:0] adr);
        bank_ofs = adr[8:2];
    endfunction

    logic [12:0] word_adr;
    logic [6:0]  ofs;
    logic        low_area;
    logic        req;
    logic        wr;
    logic        is_port;
    logic        port_sel;
    assign word_adr = WB_ADR_I[14:2];
    assign ofs      = bank_ofs(WB_ADR_I);
    assign low_area = (word_adr[6:0] < 7'h0c);
    assign req      = WB_CYC_I && WB_STB_I && (state == CSPR_WB_IDLE);
    assign wr       = req && WB_WE_I && WB_SEL_I[0] && !is_port;
    assign is_port  = low_area && (ofs == `CSPR_OFS_PORT0 || ofs == `CSPR_OFS_PORT1);
    assign port_sel = (ofs == `CSPR_OFS_PORT1);

    function automatic logic hit(input logic [6:0] o, input logic [6:0] want, input logic la);
        hit = la && (o == want);
    endfunction

    // ============================================================
    // alu flag results
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res;
    logic       is_arith;
    always_comb begin
        is_arith = (ALU_REQ.op == CSPR_ALU_ADD) || (ALU_REQ.op == CSPR_ALU_SUB);
        if (ALU_REQ.op == CSPR_ALU_SUB) begin
            sum = {1'b0, ALU_REQ.a} + {1'b0, ~ALU_REQ.b} + 9'h001;
            nib = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ~ALU_REQ.b[3:0]} + 5'h01;
        end else begin
            sum = {1'b0, ALU_REQ.a} + {1'b0, ALU_REQ.b};
            nib = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ALU_REQ.b[3:0]};
        end
        case (ALU_REQ.op)
            CSPR_ALU_ADD, CSPR_ALU_SUB: res = sum[7:0];
            CSPR_ALU_LOGIC: res = ALU_REQ.a;
            CSPR_ALU_RRC: res = {carry_flag, ALU_REQ.a[7:1]};
            CSPR_ALU_RLC: res = {ALU_REQ.a[6:0], carry_flag};
            default: res = working_accumulator;
        endcase
    end

    // ============================================================
    // status flags
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            if (POR_BOR) begin
                timeout_flag   <= 1'b1;
                powerdown_flag <= 1'b1;
            end else begin
                timeout_flag   <= RST_TIMEOUT_VAL;
                powerdown_flag <= RST_POWERDOWN_VAL;
            end
        end else begin
            if (EVENTS.watchdog_timeout) begin
                timeout_flag <= 1'b0;
            end else if (EVENTS.watchdog_clear_instr || EVENTS.sleep_instr) begin
                timeout_flag <= 1'b1;
            end
            if (EVENTS.watchdog_clear_instr) begin
                powerdown_flag <= 1'b1;
            end else if (EVENTS.sleep_instr) begin
                powerdown_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            if (POR_BOR) begin
                zero_flag        <= 1'b0;
                digit_carry_flag <= 1'b0;
                carry_flag       <= 1'b0;
            end
        end else if (ALU_REQ.op != CSPR_ALU_NONE) begin
            if (ALU_REQ.op != CSPR_ALU_RRC && ALU_REQ.op != CSPR_ALU_RLC) begin
                zero_flag <= (res == 8'h00);
            end
            if (is_arith) begin
                digit_carry_flag <= nib[4];
                carry_flag       <= sum[8];
            end else if (ALU_REQ.op == CSPR_ALU_RRC) begin
                carry_flag <= ALU_REQ.a[0];
            end else if (ALU_REQ.op == CSPR_ALU_RLC) begin
                carry_flag <= ALU_REQ.a[7];
            end
        end else if (wr && hit(ofs, `CSPR_OFS_STATUS, low_area)) begin
            zero_flag        <= WB_DAT_I[`CSPR_BIT_Z];
            digit_carry_flag <= WB_DAT_I[`CSPR_BIT_DC];
            carry_flag       <= WB_DAT_I[`CSPR_BIT_C];
        end
    end

    // ============================================================
    // pointers, bank, accumulator, latch, control
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pointer_zero <= 16'h0000;
            pointer_one  <= 16'h0000;
        end else if (wr) begin
            if (hit(ofs, `CSPR_OFS_PTR0_LO, low_area)) pointer_zero[7:0]  <= WB_DAT_I[7:0];
            if (hit(ofs, `CSPR_OFS_PTR0_HI, low_area)) pointer_zero[15:8] <= WB_DAT_I[7:0];
            if (hit(ofs, `CSPR_OFS_PTR1_LO, low_area)) pointer_one[7:0]   <= WB_DAT_I[7:0];
            if (hit(ofs, `CSPR_OFS_PTR1_HI, low_area)) pointer_one[15:8]  <= WB_DAT_I[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bank_selector  <= 6'h00;
            pc_upper_latch <= 7'h00;
        end else if (wr) begin
            if (hit(ofs, `CSPR_OFS_BANK, low_area)) bank_selector <= WB_DAT_I[5:0];
            if (hit(ofs, `CSPR_OFS_PCLATCH, low_area)) pc_upper_latch <= WB_DAT_I[6:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            working_accumulator <= 8'h00;
        end else if (ALU_REQ.op != CSPR_ALU_NONE && ALU_REQ.write_acc) begin
            working_accumulator <= res;
        end else if (wr && hit(ofs, `CSPR_OFS_ACC, low_area)) begin
            working_accumulator <= WB_DAT_I[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            interrupt_control <= `CSPR_RST_INTCTL;
        end else if (wr && hit(ofs, `CSPR_OFS_INTCTL, low_area)) begin
            interrupt_control[`CSPR_BIT_GIE]  <= WB_DAT_I[`CSPR_BIT_GIE];
            interrupt_control[`CSPR_BIT_PERIPHERAL_IRQ_ENABLE] <= WB_DAT_I[`CSPR_BIT_PERIPHERAL_IRQ_ENABLE];
            interrupt_control[`CSPR_BIT_EDG]  <= WB_DAT_I[`CSPR_BIT_EDG];
        end
    end

    // flag sets on its condition whatever the enables; set wins over clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_flag <= 1'b0;
        end else if (IRQ_COND) begin
            irq_flag <= 1'b1;
        end else if (IRQ_FLAG_CLEAR) begin
            irq_flag <= 1'b0;
        end
    end

    // ============================================================
    // return stack and window
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            return_stack_index <= 5'h00;
        end else if (wr && word_adr == `CSPR_ADR_STKIDX) begin
            return_stack_index <= WB_DAT_I[4:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (wr && word_adr == `CSPR_ADR_TOS_LO) begin
            stack_mem[return_stack_index][7:0] <= WB_DAT_I[7:0];
        end
        if (wr && word_adr == `CSPR_ADR_TOS_HI) begin
            stack_mem[return_stack_index][15:8] <= WB_DAT_I[7:0];
        end
    end

    // ============================================================
    // wishbone slave with indirect port forwarding
    logic [7:0] rd;
    logic [7:0] status_byte;
    assign status_byte = {3'h0, timeout_flag, powerdown_flag, zero_flag, digit_carry_flag, carry_flag};
    always_comb begin
        rd = 8'h00;
        if (word_adr == `CSPR_ADR_STKIDX) rd = {3'h0, return_stack_index};
        else if (word_adr == `CSPR_ADR_TOS_LO) rd = stack_mem[return_stack_index][7:0];
        else if (word_adr == `CSPR_ADR_TOS_HI) rd = stack_mem[return_stack_index][15:8];
        else if (low_area) begin
            case (ofs)
                `CSPR_OFS_STATUS:  rd = status_byte;
                `CSPR_OFS_PTR0_LO: rd = pointer_zero[7:0];
                `CSPR_OFS_PTR0_HI: rd = pointer_zero[15:8];
                `CSPR_OFS_PTR1_LO: rd = pointer_one[7:0];
                `CSPR_OFS_PTR1_HI: rd = pointer_one[15:8];
                `CSPR_OFS_BANK:    rd = {2'h0, bank_selector};
                `CSPR_OFS_ACC:     rd = working_accumulator;
                `CSPR_OFS_PCLATCH: rd = {1'b0, pc_upper_latch};
                `CSPR_OFS_INTCTL:  rd = interrupt_control & 8'hc1;
                default:           rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state          <= CSPR_WB_IDLE;
            WB_ACK_O       <= 1'b0;
            WB_DAT_O       <= 32'h0000_0000;
            INDIRECT_REQ   <= 1'b0;
            INDIRECT_WE    <= 1'b0;
            INDIRECT_ADDR  <= 16'h0000;
            INDIRECT_WDATA <= 8'h00;
        end else begin
            case (state)
                CSPR_WB_IDLE: begin
                    WB_ACK_O <= 1'b0;
                    if (req && is_port) begin
                        INDIRECT_REQ   <= 1'b1;
                        INDIRECT_WE    <= WB_WE_I && WB_SEL_I[0];
                        INDIRECT_ADDR  <= port_sel ? pointer_one : pointer_zero;
                        INDIRECT_WDATA <= WB_DAT_I[7:0];
                        state          <= CSPR_WB_ACK;
                    end else if (req) begin
                        WB_ACK_O <= 1'b1;
                        WB_DAT_O <= {24'h000000, rd};
                        state    <= CSPR_WB_REST;
                    end
                end
                CSPR_WB_ACK: begin
                    INDIRECT_REQ <= 1'b0;
                    if (INDIRECT_DONE) begin
                        WB_ACK_O <= 1'b1;
                        WB_DAT_O <= {24'h000000, INDIRECT_RDATA};
                        state    <= CSPR_WB_REST;
                    end
                end
                CSPR_WB_REST: begin
                    WB_ACK_O <= 1'b0;
                    state    <= CSPR_WB_IDLE;
                end
                default: begin
                    WB_ACK_O <= 1'b0;
                    state    <= CSPR_WB_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // registered outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            POINTER_ZERO        <= 16'h0000;
            POINTER_ONE         <= 16'h0000;
            BANK_SELECT         <= 6'h00;
            ACCUMULATOR         <= 8'h00;
            PC_LATCH            <= 7'h00;
            GLOBAL_IRQ_ENABLE   <= 1'b0;
            PERIPH_IRQ_ENABLE   <= 1'b0;
            EXT_IRQ_EDGE_SELECT <= 1'b1;
            STACK_INDEX         <= 5'h00;
            STACK_TOP           <= 16'h0000;
            STATUS_FLAGS        <= 8'h00;
            IRQ_FLAG            <= 1'b0;
        end else begin
            POINTER_ZERO        <= pointer_zero;
            POINTER_ONE         <= pointer_one;
            BANK_SELECT         <= bank_selector;
            ACCUMULATOR         <= working_accumulator;
            PC_LATCH            <= pc_upper_latch;
            GLOBAL_IRQ_ENABLE   <= interrupt_control[`CSPR_BIT_GIE];
            PERIPH_IRQ_ENABLE   <= interrupt_control[`CSPR_BIT_PERIPHERAL_IRQ_ENABLE];
            EXT_IRQ_EDGE_SELECT <= interrupt_control[`CSPR_BIT_EDG];
            STACK_INDEX         <= return_stack_index;
            STACK_TOP           <= stack_mem[return_stack_index];
            STATUS_FLAGS        <= status_byte;
            IRQ_FLAG            <= irq_flag;
        end
    end
endmodule // cspr_core_regs
`default_nettype wire

// ---- bench/cspr_chk.sv ----
// assertions on the core register block ports
`timescale 1ns/1ns
`default_nettype none
module cspr_chk (
    input wire logic                       CLK,
    input wire logic                       SYS_RST,
    input wire logic                       WB_CYC_I,
    input wire logic                       WB_STB_I,
    input wire logic                       WB_ACK_O,
    input wire cspr_pkg::cspr_alu_req_type ALU_REQ,
    input wire cspr_pkg::cspr_event_type   EVENTS,
    input wire logic [7:0]                 STATUS_FLAGS,
    input wire logic                       INDIRECT_DONE,
    input wire logic                       EXT_IRQ_EDGE_SELECT,
    input wire logic                       GLOBAL_IRQ_ENABLE
);
    import cspr_pkg::*;
    // =====
    // expected flags
    wire logic [8:0] add_s = {1'b0, ALU_REQ.a} + {1'b0, ALU_REQ.b};
    wire logic [4:0] add_n = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ALU_REQ.b[3:0]};
    wire logic [8:0] sub_s = {1'b0, ALU_REQ.a} + {1'b0, ~ALU_REQ.b} + 9'h001;
    wire logic [4:0] sub_n = {1'b0, ALU_REQ.a[3:0]} + {1'b0, ~ALU_REQ.b[3:0]} + 5'h01;
    wire logic [2:0] add_f = {add_s[7:0] == 8'h00, add_n[4], add_s[8]};
    wire logic [2:0] sub_f = {sub_s[7:0] == 8'h00, sub_n[4], sub_s[8]};
    wire logic       rot_b = (ALU_REQ.op == CSPR_ALU_RRC) ? ALU_REQ.a[0] : ALU_REQ.a[7];
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    a_ack_in_cycle: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I) else $error("ack outside a cycle");
    a_done_to_ack: assert property (INDIRECT_DONE |=> WB_ACK_O) else $error("no ack after port done");
    a_add_flags: assert property (ALU_REQ.op == CSPR_ALU_ADD |-> ##2 STATUS_FLAGS[2:0] == $past(add_f, 2))
        else $error("add flags wrong");
    a_sub_flags: assert property (ALU_REQ.op == CSPR_ALU_SUB |-> ##2 STATUS_FLAGS[2:0] == $past(sub_f, 2))
        else $error("sub flags wrong");
    a_rot_carry: assert property (ALU_REQ.op inside {CSPR_ALU_RRC, CSPR_ALU_RLC} |-> ##2 STATUS_FLAGS[0] == $past(rot_b, 2))
        else $error("rotate carry wrong");
    a_wdt_clears_to: assert property (EVENTS.watchdog_timeout |-> ##2 !STATUS_FLAGS[4]) else $error("timeout flag kept");
    a_sleep_pd: assert property (EVENTS.sleep_instr && !EVENTS.watchdog_clear_instr |-> ##2 !STATUS_FLAGS[3])
        else $error("powerdown flag kept");
    a_clear_sets: assert property (EVENTS.watchdog_clear_instr && !EVENTS.watchdog_timeout |-> ##2 STATUS_FLAGS[4:3] == 2'b11)
        else $error("clear did not set flags");
    a_reset_ctl: assert property (disable iff (1'b0) SYS_RST [*3] |-> EXT_IRQ_EDGE_SELECT && !GLOBAL_IRQ_ENABLE)
        else $error("control reset value wrong");
endmodule // cspr_chk
`default_nettype wire

// ---- bench/cspr_mem_model.sv ----
// data memory behind the indirect ports
`timescale 1ns/1ns
`default_nettype none
module cspr_mem_model (
    input  wire logic        CLK,
    input  wire logic        REQ,
    input  wire logic        WE,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic [1:0]  DELAY,
    output var  logic [7:0]  RDATA,
    output var  logic        DONE
);
    // =====
    // answers each request after DELAY cycles
    logic [7:0] mem [0:255];
    logic [7:0] a;
    initial begin
        DONE = 1'b0;
        RDATA = 8'h5a;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
        forever begin
            @(posedge CLK);
            if (REQ) begin
                a = ADDR[7:0];
                if (WE) mem[a] = WDATA;
                repeat (DELAY) @(posedge CLK);
                RDATA <= mem[a];
                DONE <= 1'b1;
                @(posedge CLK);
                DONE <= 1'b0;
                RDATA <= ~RDATA;
            end
        end
    end
endmodule // cspr_mem_model
`default_nettype wire

// ---- bench/cspr_core_regs_test.sv ----
// self-checking bench for the core register block
`timescale 1ns/1ns
`default_nettype none
`include "cspr_defs.svh"
module cspr_core_regs_test;
    import cspr_pkg::*;
    // =====
    // stimulus and model
    logic             clk, rst, por, we, cyc, stb, ack, rto, rpd, icd, icl, ifl, irq, iwe, idn;
    logic [31:0]      adr, dat, dato;
    logic [7:0]       ird, iwd, acc, st, q, a, b, v;
    logic [15:0]      iad, p0, p1, stt;
    logic [5:0]       bsel;
    logic [6:0]       pcl;
    logic [4:0]       sidx;
    logic [3:0]       sel;
    logic             global_irq_enable, pie, eds;
    logic [1:0]       dly;
    cspr_alu_req_type alu;
    cspr_event_type   ev;
    int               n_mismatch, samples_checked, seed, r, h;
    logic [7:0]       mdl [12];
    logic [7:0]       msk [12] = '{0, 0, 0, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'hc1};
    logic [2:0]       evs [6] = '{3'h1, 3'h2, 3'h1, 3'h4, 3'h7, 3'h2};
    cspr_alu_type     ops [4] = '{CSPR_ALU_ADD, CSPR_ALU_SUB, CSPR_ALU_RRC, CSPR_ALU_RLC};
    cspr_core_regs dut (.CLK(clk), .SYS_RST(rst), .POR_BOR(por), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel),
        .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dato), .WB_ACK_O(ack), .ALU_REQ(alu), .EVENTS(ev),
        .RST_TIMEOUT_VAL(rto), .RST_POWERDOWN_VAL(rpd), .IRQ_COND(icd), .IRQ_FLAG_CLEAR(icl), .IRQ_FLAG(ifl),
        .POINTER_ZERO(p0), .POINTER_ONE(p1), .BANK_SELECT(bsel), .ACCUMULATOR(acc), .PC_LATCH(pcl),
        .GLOBAL_IRQ_ENABLE(global_irq_enable), .PERIPH_IRQ_ENABLE(pie), .EXT_IRQ_EDGE_SELECT(eds), .STACK_INDEX(sidx),
        .STACK_TOP(stt), .STATUS_FLAGS(st),
        .INDIRECT_REQ(irq), .INDIRECT_WE(iwe), .INDIRECT_ADDR(iad), .INDIRECT_WDATA(iwd),
        .INDIRECT_RDATA(ird), .INDIRECT_DONE(idn));
    cspr_mem_model mem (.CLK(clk), .REQ(irq), .WE(iwe), .ADDR(iad), .WDATA(iwd), .DELAY(dly), .RDATA(ird), .DONE(idn));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [31:0] ra(input logic [7:0] bk, input int o);
        return {17'h0, bk[5:0], 7'(o), 2'b00};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic [31:0] ad, input logic w, input logic [7:0] d);
        adr <= ad;
        we <= w;
        dat <= {24'h0, d};
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = dato[7:0];
        chk("ack", 1, ack);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_all();
        for (int i = 3; i < 12; i++) begin
            bus(ra(rnd(), i), 0, 0);
            chk("reg", mdl[i], q);
        end
        chk("ptr1_out", {mdl[7], mdl[6]}, p1);
        chk("bank_out", mdl[8], {2'h0, bsel});
        chk("pclatch_out", mdl[10], {1'b0, pcl});
        chk("gie_out", mdl[11][7], global_irq_enable);
        chk("peripheral_irq_enable_out", mdl[11][6], pie);
        chk("edge_out", mdl[11][0], eds);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        {rst, por, we, cyc, stb, rto, rpd, icd, icl, dly, adr, dat, alu, ev} = '0;
        sel = 4'h1;
        {rst, por, seed} = {1'b1, 1'b1, 32'd75};
        for (int i = 0; i < 12; i++) mdl[i] = (i == 11) ? 8'h01 : (i == 3) ? 8'h18 : 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd_all();
        for (int i = 3; i < 13; i++) begin
            v = rnd();
            bus(ra(rnd(), i), 1, v);
            if (i < 12) mdl[i] = (mdl[i] & ~msk[i]) | (v & msk[i]);
        end
        rd_all();
        bus(ra(0, 12), 0, 0);
        chk("unmapped", 0, q);
        chk("ptr0", {mdl[5], mdl[4]}, p0);
        for (int i = 0; i < 32; i++) begin
            {a, b} = {rnd(), rnd()};
            alu <= '{op: ops[i % 4], a: a, b: b, write_acc: (i % 4) < 2};
            @(posedge clk);
            alu <= '0;
            r = (i % 4 == 1) ? a + (~b & 255) + 1 : a + b;
            h = (i % 4 == 1) ? (a & 15) + (~b & 15) + 1 : (a & 15) + (b & 15);
            if (i % 4 < 2) mdl[3][2:0] = {r[7:0] == 0, h > 15, r > 255};
            if (i % 4 < 2) mdl[9] = r[7:0];
            if (i % 4 > 1) mdl[3][0] = (i % 4 == 2) ? a[0] : a[7];
            repeat (2) @(posedge clk);
            chk("flags", mdl[3], st);
            chk("acc", mdl[9], acc);
        end
        foreach (evs[i]) begin
            ev <= cspr_event_type'(evs[i]);
            @(posedge clk);
            ev <= '0;
            mdl[3][4] = !evs[i][0];
            if (evs[i][2] || evs[i][1]) mdl[3][3] = evs[i][2];
            repeat (2) @(posedge clk);
            chk("status", mdl[3], st);
        end
        for (int k = 0; k < 2; k++) begin
            icd <= !k[0];
            icl <= k[0];
            @(posedge clk);
            {icd, icl} <= 2'b00;
            repeat (2) @(posedge clk);
            chk("irq", !k[0], ifl);
            v = 8'(16 * k) | (rnd() & 8'h07);
            dly = 2'(3 * k);
            bus(ra(0, 4), 1, v);
            bus(ra(0, 0), 0, 0);
            chk("port0", v ^ 8'h3c, q);
            bus(ra(0, 6), 1, v + 8);
            bus(ra(0, 1), 1, 8'ha5);
            bus(ra(0, 4), 1, v + 8);
            bus(ra(0, 0), 0, 0);
            chk("port1", 8'ha5, q);
            bus({17'h0, `CSPR_ADR_STKIDX, 2'b00}, 1, 8'(5 + 4 * k));
            bus({17'h0, `CSPR_ADR_TOS_LO, 2'b00}, 1, 8'(8'h30 + k));
            bus({17'h0, `CSPR_ADR_TOS_HI, 2'b00}, 1, 8'(8'h60 + k));
        end
        bus({17'h0, `CSPR_ADR_STKIDX, 2'b00}, 1, 8'h05);
        bus({17'h0, `CSPR_ADR_TOS_LO, 2'b00}, 0, 0);
        chk("tos_lo", 8'h30, q);
        bus({17'h0, `CSPR_ADR_TOS_HI, 2'b00}, 0, 0);
        chk("tos_hi", 8'h60, q);
        chk("stk_idx_out", 16'h0005, sidx);
        chk("stk_top_out", 16'h6030, stt);
        sel <= 4'h0;
        bus(ra(0, 9), 1, 8'h77);
        sel <= 4'h1;
        bus(ra(0, 9), 0, 0);
        chk("sel_off", mdl[9], q);
        {por, rto, rpd, rst} <= 4'b0011;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 4; i < 12; i++) mdl[i] = (i == 11) ? 8'h01 : 8'h00;
        mdl[3][4:3] = 2'b01;
        rd_all();
        stop_test();
    end
endmodule // cspr_core_regs_test
bind cspr_core_regs cspr_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .ALU_REQ(ALU_REQ), .EVENTS(EVENTS), .STATUS_FLAGS(STATUS_FLAGS),
    .INDIRECT_DONE(INDIRECT_DONE), .EXT_IRQ_EDGE_SELECT(EXT_IRQ_EDGE_SELECT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
`default_nettype wire
